// *** hdl/io_port_pkg.sv ***
// Package with register map, reset values and carrier types of the port set.
package io_port_pkg;

	// ==========================================================
	// Register map
	localparam int          NUM_REGS        = 12;
	localparam int          ADDR_W          = 4;
	localparam logic [3:0]  ZERO_LATCH      = 4'h0;
	localparam logic [3:0]  ZERO_DIR        = 4'h1;
	localparam logic [3:0]  ONE_LATCH       = 4'h2;
	localparam logic [3:0]  ONE_DIR         = 4'h3;
	localparam logic [3:0]  TWO_LATCH       = 4'h4;
	localparam logic [3:0]  SERIAL_LATCH    = 4'h5;
	localparam logic [3:0]  PWM_LATCH       = 4'h6;
	localparam logic [3:0]  ANA_A_LATCH     = 4'h7;
	localparam logic [3:0]  ANA_A_CTRL      = 4'h8;
	localparam logic [3:0]  ANA_B_LATCH     = 4'h9;
	localparam logic [3:0]  ANA_B_CTRL      = 4'ha;
	localparam logic [3:0]  MISC_CTRL       = 4'hb;

	// ==========================================================
	// Reset values
	localparam logic [7:0] RESET_VAL [NUM_REGS] = '{
		8'h00, 8'h00, 8'h00, 8'h00, 8'h07, 8'hff,
		8'h1f, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
	localparam logic [7:0] ALL_ONES   = 8'hff;
	localparam logic [7:0] ALL_ZEROS  = 8'h00;
	localparam logic [7:0] TWO_MASK   = 8'h07;
	localparam logic [7:0] PWM_MASK   = 8'h1f;

	// ==========================================================
	// Alternate pin positions
	localparam int TIMER_TWO_BIT    = 5;
	localparam int PULSE_BIT        = 4;
	localparam int DIVIDER_BIT      = 3;
	localparam int IRQ_THREE_BIT    = 2;
	localparam int IRQ_FIVE_BIT     = 0;
	localparam int SO_TWO_BIT       = 7;
	localparam int SI_TWO_BIT       = 6;
	localparam int SCK_TWO_BIT      = 5;
	localparam int SO_ONE_BIT       = 4;
	localparam int SI_ONE_BIT       = 3;
	localparam int SCK_ONE_BIT      = 2;
	localparam int FAST_B_BIT       = 4;
	localparam int FAST_A_BIT       = 3;
	localparam int PWM_DIV_BIT      = 2;
	localparam int IRQ_FOUR_BIT     = 1;
	localparam int IRQ_THREE_P_BIT  = 0;
	localparam int STOP_SEL_BIT     = 0;

	// ==========================================================
	// Carriers
	typedef struct packed {
		logic [7:0] out;
		logic [7:0] oe;
	} pin_drive_t;

	typedef struct packed {
		logic pulse_pattern_out;
		logic divider_out;
		logic serial_one_data_out;
		logic serial_one_clock_out;
		logic serial_one_clock_int;
		logic serial_two_data_out;
		logic serial_two_clock_out;
		logic serial_two_clock_int;
		logic fast_pwm_out_a;
		logic fast_pwm_out_b;
		logic pwm_or_divider_out;
	} alt_out_t;

	typedef struct packed {
		logic       ext_irq_two;
		logic       ext_irq_three;
		logic       ext_irq_four;
		logic       ext_irq_five;
		logic       stop_release;
		logic       timer_one_in;
		logic       timer_two_in;
		logic       timer_three_in;
		logic       timer_four_in;
		logic       serial_one_clock;
		logic       serial_one_data_in;
		logic       serial_two_clock;
		logic       serial_two_data_in;
		logic [7:0] analog_sel_a;
		logic [7:0] analog_sel_b;
	} alt_in_t;

endpackage : io_port_pkg

// *** hdl/multiplexed_io_port_set.sv ***
// Seven multiplexed parallel ports with latches, direction control and alternate pins.
//
// Function
// (RL1) Two 8-bit ports, per-bit direction by software.
// (RL2) Reset makes every programmable bit an input.
// (RL3) Latch one before pulse or divider output.
// (RL4) 3-bit latched port; latch one for alternates.
// (RL5) Serial port latch one for input/serial.
// (RL6) 5-bit port: PWM outputs, irq/timer inputs.
// (RL7) Two 8-bit analog ports, control selects analog.
// (RL8) One pin: interrupt or stop release input.
// (RL9) One pin feeds irq two and timer one.
// (RL10) Two pins feed irq/timer pairs on 5-bit port.
// (RL11) Serial clocks driven internally, received externally.
// (RL12) Inputs read pin; outputs drive latch value.
`timescale 1ns/100ps
`default_nettype none

module multiplexed_io_port_set
	import io_port_pkg::*;
(
	input  wire logic              clock,
	input  wire logic              rst_n,
	input  wire logic [ADDR_W-1:0] addr,
	input  wire logic [7:0]        wdata,
	input  wire logic              wr_en,
	input  wire logic              rd_en,
	output var  logic [7:0]        rdata,
	input  wire logic [7:0]        port_zero_pins_in,
	input  wire logic [7:0]        port_one_pins_in,
	input  wire logic [2:0]        port_two_pins_in,
	input  wire logic [7:0]        serial_pin_port_in,
	input  wire logic [4:0]        pwm_pin_port_in,
	input  wire logic [7:0]        analog_port_a_in,
	input  wire logic [7:0]        analog_port_b_in,
	output var  pin_drive_t        port_zero_pins_drv,
	output var  pin_drive_t        port_one_pins_drv,
	output var  pin_drive_t        port_two_pins_drv,
	output var  pin_drive_t        serial_pin_port_drv,
	output var  pin_drive_t        pwm_pin_port_drv,
	output var  pin_drive_t        analog_port_a_drv,
	output var  pin_drive_t        analog_port_b_drv,
	input  wire alt_out_t          alt_out,
	output var  alt_in_t           alt_in
);

	// ==========================================================
	// Register file
	logic [7:0] regs_q [NUM_REGS];

	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_ff @(posedge clock or negedge rst_n) begin
				if (!rst_n) begin
					regs_q[gi] <= RESET_VAL[gi]; // see (RL2)
				end else if (wr_en && addr == ADDR_W'(gi)) begin
					regs_q[gi] <= wdata; // see (RL1)
				end
			end
		end
	endgenerate

	wire logic [7:0] zero_latch = regs_q[ZERO_LATCH];
	wire logic [7:0] zero_dir   = regs_q[ZERO_DIR];
	wire logic [7:0] one_latch  = regs_q[ONE_LATCH];
	wire logic [7:0] one_dir    = regs_q[ONE_DIR];
	wire logic [7:0] two_latch  = regs_q[TWO_LATCH] & TWO_MASK;
	wire logic [7:0] ser_latch  = regs_q[SERIAL_LATCH];
	wire logic [7:0] pwm_latch  = regs_q[PWM_LATCH] & PWM_MASK;
	wire logic [7:0] a_latch    = regs_q[ANA_A_LATCH];
	wire logic [7:0] a_ctrl     = regs_q[ANA_A_CTRL];
	wire logic [7:0] b_latch    = regs_q[ANA_B_LATCH];
	wire logic [7:0] b_ctrl     = regs_q[ANA_B_CTRL];
	wire logic       stop_sel   = regs_q[MISC_CTRL][STOP_SEL_BIT];

	// ==========================================================
	// Alternate output values, one where the pin carries no alternate
	// Alternates are ANDed into the latch, so a latch left at zero pins
	// the line low; that is why software must hold the latch at one.
	wire logic [7:0] one_alt = ALL_ONES
		& ~(8'h01 << PULSE_BIT) & ~(8'h01 << DIVIDER_BIT)
		| ({7'h00, alt_out.pulse_pattern_out} << PULSE_BIT)
		| ({7'h00, alt_out.divider_out} << DIVIDER_BIT); // see (RL3)

	wire logic sck_one_val = alt_out.serial_one_clock_int ? alt_out.serial_one_clock_out : 1'b1;
	wire logic sck_two_val = alt_out.serial_two_clock_int ? alt_out.serial_two_clock_out : 1'b1;

	wire logic [7:0] ser_alt = ALL_ONES
		& ~(8'h01 << SO_TWO_BIT) & ~(8'h01 << SCK_TWO_BIT)
		& ~(8'h01 << SO_ONE_BIT) & ~(8'h01 << SCK_ONE_BIT)
		| ({7'h00, alt_out.serial_two_data_out} << SO_TWO_BIT)
		| ({7'h00, sck_two_val} << SCK_TWO_BIT)
		| ({7'h00, alt_out.serial_one_data_out} << SO_ONE_BIT)
		| ({7'h00, sck_one_val} << SCK_ONE_BIT); // see (RL11)

	wire logic [7:0] pwm_alt = PWM_MASK
		& ~(8'h01 << FAST_B_BIT) & ~(8'h01 << FAST_A_BIT) & ~(8'h01 << PWM_DIV_BIT)
		| ({7'h00, alt_out.fast_pwm_out_b} << FAST_B_BIT)
		| ({7'h00, alt_out.fast_pwm_out_a} << FAST_A_BIT)
		| ({7'h00, alt_out.pwm_or_divider_out} << PWM_DIV_BIT); // see (RL6)

	// ==========================================================
	// Pin drive decode
	// The 3-bit, serial and 5-bit ports only ever pull low; a one releases the line so the
	// same pin can serve as an input without a direction register.
	pin_drive_t zero_d, one_d, two_d, ser_d, pwm_d, ana_a_d, ana_b_d;

	assign zero_d.out  = zero_latch; // see (RL12)
	assign zero_d.oe   = zero_dir; // see (RL1)
	assign one_d.out   = one_latch & one_alt; // see (RL3)
	assign one_d.oe    = one_dir; // see (RL1)
	assign two_d.out   = ALL_ZEROS;
	assign two_d.oe    = ~two_latch & TWO_MASK; // see (RL4)
	assign ser_d.out   = ALL_ZEROS;
	assign ser_d.oe    = ~(ser_latch & ser_alt); // see (RL5)
	assign pwm_d.out   = ALL_ZEROS;
	assign pwm_d.oe    = ~(pwm_latch & pwm_alt) & PWM_MASK; // see (RL6)
	assign ana_a_d.out = a_latch;
	assign ana_a_d.oe  = a_ctrl; // see (RL7)
	assign ana_b_d.out = b_latch;
	assign ana_b_d.oe  = b_ctrl; // see (RL7)

	// ==========================================================
	// Pins seen by the on-chip peripherals
	alt_in_t alt_in_d;
	wire logic irq_five_pin = port_two_pins_in[IRQ_FIVE_BIT];

	assign alt_in_d.ext_irq_five       = irq_five_pin & ~stop_sel; // see (RL8)
	assign alt_in_d.stop_release       = irq_five_pin & stop_sel; // see (RL8)
	assign alt_in_d.ext_irq_two        = port_one_pins_in[IRQ_THREE_BIT]; // see (RL9)
	assign alt_in_d.timer_one_in       = port_one_pins_in[IRQ_THREE_BIT]; // see (RL9)
	assign alt_in_d.timer_two_in       = port_one_pins_in[TIMER_TWO_BIT];
	assign alt_in_d.ext_irq_four       = pwm_pin_port_in[IRQ_FOUR_BIT]; // see (RL10)
	assign alt_in_d.timer_four_in      = pwm_pin_port_in[IRQ_FOUR_BIT]; // see (RL10)
	assign alt_in_d.ext_irq_three      = pwm_pin_port_in[IRQ_THREE_P_BIT]; // see (RL10)
	assign alt_in_d.timer_three_in     = pwm_pin_port_in[IRQ_THREE_P_BIT]; // see (RL10)
	assign alt_in_d.serial_one_clock   = serial_pin_port_in[SCK_ONE_BIT]; // see (RL11)
	assign alt_in_d.serial_two_clock   = serial_pin_port_in[SCK_TWO_BIT]; // see (RL11)
	assign alt_in_d.serial_one_data_in = serial_pin_port_in[SI_ONE_BIT];
	assign alt_in_d.serial_two_data_in = serial_pin_port_in[SI_TWO_BIT];
	assign alt_in_d.analog_sel_a       = ~a_ctrl; // see (RL7)
	assign alt_in_d.analog_sel_b       = ~b_ctrl; // see (RL7)

	// ==========================================================
	// Read decode
	// Programmable ports return the pin for inputs and the latch for
	// outputs, so a read-modify-write never disturbs output bits.
	wire logic [7:0] zero_rd = (zero_dir & zero_latch) | (~zero_dir & port_zero_pins_in);
	wire logic [7:0] one_rd  = (one_dir & one_latch) | (~one_dir & port_one_pins_in);
	wire logic [7:0] a_rd    = (a_ctrl & a_latch) | (~a_ctrl & analog_port_a_in);
	wire logic [7:0] b_rd    = (b_ctrl & b_latch) | (~b_ctrl & analog_port_b_in);

	wire logic [7:0] rdata_d =
		!rd_en                ? ALL_ZEROS :
		addr == ZERO_LATCH    ? zero_rd :
		addr == ONE_LATCH     ? one_rd :
		addr == TWO_LATCH     ? {5'h00, port_two_pins_in} :
		addr == SERIAL_LATCH  ? serial_pin_port_in :
		addr == PWM_LATCH     ? {3'h0, pwm_pin_port_in} :
		addr == ANA_A_LATCH   ? a_rd :
		addr == ANA_B_LATCH   ? b_rd :
		addr < ADDR_W'(NUM_REGS) ? regs_q[addr] :
		ALL_ZEROS; // see (RL12)

	// ==========================================================
	// Output flops
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			rdata               <= ALL_ZEROS;
			port_zero_pins_drv  <= '0; // see (RL2)
			port_one_pins_drv   <= '0; // see (RL2)
			port_two_pins_drv   <= '0;
			serial_pin_port_drv <= '0;
			pwm_pin_port_drv    <= '0;
			analog_port_a_drv   <= '0;
			analog_port_b_drv   <= '0;
			alt_in              <= '0;
		end else begin
			rdata               <= rdata_d;
			port_zero_pins_drv  <= zero_d;
			port_one_pins_drv   <= one_d;
			port_two_pins_drv   <= two_d;
			serial_pin_port_drv <= ser_d;
			pwm_pin_port_drv    <= pwm_d;
			analog_port_a_drv   <= ana_a_d;
			analog_port_b_drv   <= ana_b_d;
			alt_in              <= alt_in_d;
		end
	end

	// ==========================================================
	// Assertions
	sequence s_dir_write(logic [3:0] a);
		wr_en && addr == a;
	endsequence

	a_reset_all_inputs: assert property ( // see (RL2)
		@(posedge clock) disable iff (!rst_n)
		$rose(rst_n) |-> port_zero_pins_drv.oe == 8'h00 && port_one_pins_drv.oe == 8'h00)
		else $error("programmable port driven right after reset");

	a_zero_dir_write: assert property ( // see (RL1)
		@(posedge clock) disable iff (!rst_n)
		s_dir_write(ZERO_DIR) |=> ##1 port_zero_pins_drv.oe == $past(wdata, 2))
		else $error("port zero direction did not follow write");

	a_output_drives_latch: assert property ( // see (RL12)
		@(posedge clock) disable iff (!rst_n)
		s_dir_write(ZERO_LATCH) ##1 (!wr_en || addr != ZERO_LATCH)[*2] |->
			port_zero_pins_drv.out == $past(wdata, 2))
		else $error("port zero output not the latch value");

	a_input_read_pin: assert property ( // see (RL12)
		@(posedge clock) disable iff (!rst_n)
		rd_en && addr == ONE_LATCH && one_dir == 8'h00 |=> rdata == $past(port_one_pins_in))
		else $error("input read did not return pin level");

	a_pulse_needs_latch: assert property ( // see (RL3)
		@(posedge clock) disable iff (!rst_n)
		!one_latch[PULSE_BIT] |=> !port_one_pins_drv.out[PULSE_BIT])
		else $error("pulse output seen with latch clear");

	a_stop_release_route: assert property ( // see (RL8)
		@(posedge clock) disable iff (!rst_n)
		stop_sel && irq_five_pin |=> alt_in.stop_release && !alt_in.ext_irq_five)
		else $error("stop release not routed");

	a_irq_timer_pair: assert property ( // see (RL9)
		@(posedge clock) disable iff (!rst_n)
		rst_n |=> alt_in.ext_irq_two == $past(port_one_pins_in[IRQ_THREE_BIT])
			&& alt_in.timer_one_in == alt_in.ext_irq_two)
		else $error("irq and timer one input disagree");

	a_pwm_port_inputs: assert property ( // see (RL10)
		@(posedge clock) disable iff (!rst_n)
		rst_n |=> alt_in.timer_four_in == $past(pwm_pin_port_in[IRQ_FOUR_BIT])
			&& alt_in.timer_three_in == $past(pwm_pin_port_in[IRQ_THREE_P_BIT]))
		else $error("5-bit port inputs not routed");

	a_sck_internal_drive: assert property ( // see (RL11)
		@(posedge clock) disable iff (!rst_n)
		rst_n && alt_out.serial_one_clock_int && ser_latch[SCK_ONE_BIT]
			&& !alt_out.serial_one_clock_out |=> serial_pin_port_drv.oe[SCK_ONE_BIT])
		else $error("internal serial clock low not driven");

	a_two_port_release: assert property ( // see (RL4)
		@(posedge clock) disable iff (!rst_n)
		two_latch == TWO_MASK |=> port_two_pins_drv.oe == 8'h00)
		else $error("3-bit port driven with latch at one");

	a_analog_select: assert property ( // see (RL7)
		@(posedge clock) disable iff (!rst_n)
		s_dir_write(ANA_A_CTRL) |=> ##1 alt_in.analog_sel_a == ~$past(wdata, 2))
		else $error("analog select does not follow control");

	// The sampled rst_n in an antecedent keeps the release edge out, where the
	// registers still hold reset values but the drive flops were just cleared.
	a_one_dir_write: assert property ( // see (RL1)
		@(posedge clock) disable iff (!rst_n)
		s_dir_write(ONE_DIR) |=> ##1 port_one_pins_drv.oe == $past(wdata, 2))
		else $error("port one direction did not follow write");

	a_divider_needs_latch: assert property ( // see (RL3)
		@(posedge clock) disable iff (!rst_n)
		!one_latch[DIVIDER_BIT] |=> !port_one_pins_drv.out[DIVIDER_BIT])
		else $error("divider output seen with latch clear");

	a_two_port_upper: assert property ( // see (RL4)
		@(posedge clock) disable iff (!rst_n)
		port_two_pins_drv.out == 8'h00 && port_two_pins_drv.oe[7:3] == 5'h00)
		else $error("3-bit port drives beyond its pins");

	a_pwm_input_release: assert property ( // see (RL6)
		@(posedge clock) disable iff (!rst_n)
		pwm_latch[IRQ_FOUR_BIT] |=> !pwm_pin_port_drv.oe[IRQ_FOUR_BIT])
		else $error("pwm port input pulled low with latch at one");

	a_fast_pwm_drive: assert property ( // see (RL6)
		@(posedge clock) disable iff (!rst_n)
		rst_n && pwm_latch[FAST_A_BIT] && !alt_out.fast_pwm_out_a
			|=> pwm_pin_port_drv.oe[FAST_A_BIT])
		else $error("fast pwm low level not driven");

	a_analog_b_select: assert property ( // see (RL7)
		@(posedge clock) disable iff (!rst_n)
		s_dir_write(ANA_B_CTRL) |=> ##1 alt_in.analog_sel_b == ~$past(wdata, 2))
		else $error("analog b select does not follow control");

	a_irq_five_route: assert property ( // see (RL8)
		@(posedge clock) disable iff (!rst_n)
		rst_n && !stop_sel
			|=> alt_in.ext_irq_five == $past(irq_five_pin) && !alt_in.stop_release)
		else $error("interrupt five not routed");

	a_sck_external_release: assert property ( // see (RL11)
		@(posedge clock) disable iff (!rst_n)
		rst_n && !alt_out.serial_two_clock_int && ser_latch[SCK_TWO_BIT]
			|=> !serial_pin_port_drv.oe[SCK_TWO_BIT])
		else $error("external serial clock pin not released");

	a_read_idle_zero: assert property ( // see (RL12)
		@(posedge clock) disable iff (!rst_n)
		!rd_en |=> rdata == 8'h00)
		else $error("read data seen without a read");

	a_read_unmapped: assert property ( // see (RL12)
		@(posedge clock) disable iff (!rst_n)
		rd_en && addr >= ADDR_W'(NUM_REGS) |=> rdata == 8'h00)
		else $error("unmapped read returned data");

endmodule : multiplexed_io_port_set

`default_nettype wire

// *** verification/board_circuitry_model.sv ***
// Board circuitry model that resolves every port pin from the block's drives and the board levels.
`timescale 1ns/100ps
`default_nettype none

module board_circuitry_model
	import io_port_pkg::*;
(
	input  wire pin_drive_t  zero_drv,
	input  wire pin_drive_t  one_drv,
	input  wire pin_drive_t  two_drv,
	input  wire pin_drive_t  serial_drv,
	input  wire pin_drive_t  pwm_drv,
	input  wire pin_drive_t  ana_a_drv,
	input  wire pin_drive_t  ana_b_drv,
	input  wire logic [47:0] ext_levels,
	output var  logic [47:0] pin_levels
);
	// ==========================================================
	// Pin resolution
	// A tri-state pin shows the block's value only where it drives; elsewhere the board level.
	function automatic logic [7:0] tri_pin(input pin_drive_t d, input logic [7:0] ext);
		return (d.oe & d.out) | (~d.oe & ext);
	endfunction : tri_pin

	// Open-drain pins have board pull-ups, so a released pin shows the board level, never a stale one.
	function automatic logic [7:0] od_pin(input pin_drive_t d, input logic [7:0] ext);
		return ~d.oe & ext;
	endfunction : od_pin

	always_comb begin
		pin_levels[47:40] = tri_pin(zero_drv, ext_levels[47:40]);
		pin_levels[39:32] = tri_pin(one_drv, ext_levels[39:32]);
		pin_levels[31:29] = od_pin(two_drv, {5'h00, ext_levels[31:29]}) & 8'h07;
		pin_levels[28:21] = od_pin(serial_drv, ext_levels[28:21]);
		pin_levels[20:16] = od_pin(pwm_drv, {3'h0, ext_levels[20:16]}) & 8'h1f;
		pin_levels[15:8]  = tri_pin(ana_a_drv, ext_levels[15:8]);
		pin_levels[7:0]   = tri_pin(ana_b_drv, ext_levels[7:0]);
	end
endmodule : board_circuitry_model

`default_nettype wire

// *** verification/multiplexed_io_port_set_test.sv ***
// Self-checking testbench of the multiplexed port set with a queue-based scoreboard.
`timescale 1ns/100ps
`default_nettype none

module multiplexed_io_port_set_test
	import io_port_pkg::*;
;
	typedef struct {int due; int sel; logic [7:0] exp; logic [7:0] mask;} note_t;

	logic              clock = 1'b0;
	logic              rst_n = 1'b0;
	logic [ADDR_W-1:0] addr;
	logic [7:0]        wdata;
	logic              wr_en;
	logic              rd_en;
	logic [7:0]        rdata;
	alt_out_t          alt_out;
	alt_in_t           alt_in;
	pin_drive_t        drv [7];
	logic [47:0]       ext;
	logic [47:0]       pins;
	int                cyc = 0;
	int                n_mismatch = 0;
	int                comparisons = 0;
	note_t             notes [$];
	logic [7:0]        e;
	logic [7:0]        lat;
	logic [7:0]        dir;

	always #20 clock = ~clock;
	always @(posedge clock) cyc <= cyc + 1;

	multiplexed_io_port_set multiplexed_io_port_set_inst (.clock(clock), .rst_n(rst_n),
		.addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata),
		.port_zero_pins_in(pins[47:40]), .port_one_pins_in(pins[39:32]),
		.port_two_pins_in(pins[31:29]), .serial_pin_port_in(pins[28:21]),
		.pwm_pin_port_in(pins[20:16]), .analog_port_a_in(pins[15:8]), .analog_port_b_in(pins[7:0]),
		.port_zero_pins_drv(drv[0]), .port_one_pins_drv(drv[1]), .port_two_pins_drv(drv[2]),
		.serial_pin_port_drv(drv[3]), .pwm_pin_port_drv(drv[4]), .analog_port_a_drv(drv[5]),
		.analog_port_b_drv(drv[6]), .alt_out(alt_out), .alt_in(alt_in));

	board_circuitry_model board_circuitry_model_inst (.zero_drv(drv[0]), .one_drv(drv[1]),
		.two_drv(drv[2]), .serial_drv(drv[3]), .pwm_drv(drv[4]), .ana_a_drv(drv[5]),
		.ana_b_drv(drv[6]), .ext_levels(ext), .pin_levels(pins));

	// ==========================================================
	// Scoreboard
	string sel_name [15] = '{"rdata", "zero_oe", "zero_out", "one_oe", "one_out", "two_oe",
		"serial_oe", "pwm_oe", "ana_a_oe", "ana_b_oe", "ana_sel_a", "ana_sel_b", "irq_timer_in",
		"serial_clock_in", "serial_out"};

	function automatic logic [7:0] observe(input int sel);
		case (sel)
			0: return rdata;
			1: return drv[0].oe;
			2: return drv[0].out;
			3: return drv[1].oe;
			4: return drv[1].out;
			5: return drv[2].oe;
			6: return drv[3].oe;
			7: return drv[4].oe;
			8: return drv[5].oe;
			9: return drv[6].oe;
			10: return alt_in.analog_sel_a;
			11: return alt_in.analog_sel_b;
			12: return {alt_in.ext_irq_two, alt_in.timer_one_in, alt_in.ext_irq_three,
				alt_in.timer_three_in, alt_in.ext_irq_four, alt_in.timer_four_in,
				alt_in.ext_irq_five, alt_in.stop_release};
			13: return {6'h00, alt_in.serial_two_clock, alt_in.serial_one_clock};
			default: return drv[3].out;
		endcase
	endfunction : observe

	task automatic check(input int sel, input logic [7:0] exp, input logic [7:0] mask);
		logic [7:0] seen;
		seen = observe(sel) & mask;
		comparisons++;
		if (seen !== (exp & mask)) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", sel_name[sel], exp & mask, seen);
		end
	endtask : check

	// Results are compared on the falling edge, well away from the edge that launches them.
	always @(negedge clock) begin
		while (notes.size() > 0 && notes[0].due <= cyc) begin
			check(notes[0].sel, notes[0].exp, notes[0].mask);
			void'(notes.pop_front());
		end
	end

	task automatic note(input int sel, input logic [7:0] exp, input logic [7:0] mask, input int lag);
		notes.push_back('{cyc + lag, sel, exp, mask});
	endtask : note

	// ==========================================================
	// Bus master
	task automatic wait_cycles(input int n);
		repeat (n) @(posedge clock);
	endtask : wait_cycles

	task automatic wr(input logic [3:0] a, input logic [7:0] d);
		@(posedge clock);
		wr_en <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clock);
		wr_en <= 1'b0;
	endtask : wr

	// Read data stand only in the cycle after the strobe, and are zero one cycle later.
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clock);
		rd_en <= 1'b1;
		addr <= a;
		@(posedge clock);
		rd_en <= 1'b0;
		note(0, exp, 8'hff, 1);
		note(0, 8'h00, 8'hff, 2);
	endtask : rd

	task automatic tally_and_finish;
		$display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask : tally_and_finish

	initial begin
		repeat (5000) @(posedge clock);
		n_mismatch++;
		tally_and_finish();
	end

	// ==========================================================
	// Main sequence
	initial begin
		addr = '0;
		wdata = '0;
		wr_en = 1'b0;
		rd_en = 1'b0;
		alt_out = '1;
		ext = '1;
		void'($urandom(32'hd6756902));
		wait_cycles(3);
		rst_n <= 1'b1;
		wait_cycles(2);
		note(1, 8'h00, 8'hff, 1);
		note(3, 8'h00, 8'hff, 1);
		note(8, 8'h00, 8'hff, 1);
		// Latched and analog reads return the released pins, which the board holds high.
		foreach (sel_name[a]) begin
			e = (a > 4 && a < 10) ? 8'hff : 8'h00;
			if (a < 12 && a[0]) rd(ADDR_W'(a), e);
		end
		rd(MISC_CTRL, 8'h00);
		$display("Test reset done");
		for (int i = 0; i < 4; i++) begin
			lat = 8'($urandom);
			dir = 8'($urandom);
			e = 8'($urandom);
			wr(ZERO_LATCH, lat);
			wr(ZERO_DIR, dir);
			wr(ONE_LATCH, lat);
			wr(ONE_DIR, ~dir);
			wr(ANA_A_CTRL, dir);
			wr(ANA_B_CTRL, ~dir);
			ext[47:32] <= {e, ~e};
			alt_out.pulse_pattern_out <= e[1];
			alt_out.divider_out <= e[2];
			wait_cycles(4);
			note(1, dir, 8'hff, 1);
			note(2, lat, 8'hff, 1);
			note(3, ~dir, 8'hff, 1);
			note(4, lat & ~{3'h0, ~e[1], ~e[2], 3'h0}, 8'hff, 1);
			note(8, dir, 8'hff, 1);
			note(9, ~dir, 8'hff, 1);
			note(10, ~dir, 8'hff, 1);
			note(11, dir, 8'hff, 1);
			rd(ZERO_LATCH, (dir & lat) | (~dir & e));
			rd(ONE_LATCH, (~dir & lat) | (dir & ~e));
			wr(4'hc + 4'(i), lat);
			rd(4'hc + 4'(i), 8'h00);
		end
		$display("Test direction and latch done");
		wr(ONE_DIR, 8'h00);
		for (int m = 0; m < 4; m++) begin
			e = 8'($urandom);
			e[1] = e[1] | (m == 3);
			wr(MISC_CTRL, 8'(m));
			ext[34] <= e[0];
			ext[29] <= e[1];
			ext[17:16] <= e[3:2];
			wait_cycles(4);
			lat = {e[0], e[0], e[2], e[2], e[3], e[3], ~m[0] & e[1], m[0] & e[1]};
			note(12, lat, 8'hff, 1);
			rd(ONE_LATCH, ext[39:32]);
		end
		$display("Test alternate inputs done");
		// The serial latch keeps its reset value of all ones, as the serial pins require.
		for (int k = 0; k < 4; k++) begin
			e = 8'($urandom);
			alt_out.serial_one_clock_int <= k[0];
			alt_out.serial_two_clock_int <= k[1];
			alt_out.serial_one_clock_out <= e[0];
			alt_out.serial_two_clock_out <= e[1];
			ext[23] <= e[3];
			ext[26] <= e[2];
			wait_cycles(4);
			note(6, {2'h0, k[1] & ~e[1], 2'h0, k[0] & ~e[0], 2'h0}, 8'h24, 1);
			note(13, {6'h00, e[2], e[3]}, {6'h00, ~k[1], ~k[0]}, 1);
			note(14, 8'h00, 8'hff, 1);
		end
		$display("Test serial clocks done");
		for (int i = 0; i < 4; i++) begin
			e = 8'($urandom);
			lat = 8'($urandom) | 8'h03;
			wr(PWM_LATCH, lat);
			wr(TWO_LATCH, {5'h00, e[7:6], 1'b0});
			alt_out.fast_pwm_out_a <= e[0];
			alt_out.fast_pwm_out_b <= e[1];
			alt_out.pwm_or_divider_out <= e[2];
			wait_cycles(4);
			note(7, ~(lat & {3'h0, e[1], e[0], e[2], 2'h3}), 8'h1c, 1);
			note(5, {5'h00, ~e[7], ~e[6], 1'b1}, 8'hff, 1);
		end
		wr(TWO_LATCH, 8'h07);
		$display("Test open drain ports done");
		wr(ZERO_DIR, 8'hff);
		wait_cycles(4);
		rst_n <= 1'b0;
		wait_cycles(2);
		note(1, 8'h00, 8'hff, 1);
		note(3, 8'h00, 8'hff, 1);
		wait_cycles(2);
		rst_n <= 1'b1;
		wait_cycles(2);
		rd(ZERO_DIR, 8'h00);
		wait_cycles(6);
		$display("Test second reset done");
		tally_and_finish();
	end
endmodule : multiplexed_io_port_set_test

`default_nettype wire
